// >>> i2c_timing_pkg.sv
// constants, register map and state type for the i2c timing and bus watchdog block
// assumes one link-side clock period of CLK_NS for every time-to-cycle conversion
package i2c_timing_pkg;
    // ------------------------------------------------------------
    // clock and counter widths
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int NSW    = 15;
    localparam int WDW    = 26;
    localparam int AW     = 8;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL_ONE = 6'h08;
    localparam logic [5:0] IDX_CTRL_TWO = 6'h09;
    localparam logic [5:0] IDX_HIGH     = 6'h0A;
    localparam logic [5:0] IDX_LOW      = 6'h0B;
    localparam logic [5:0] IDX_RSVD     = 6'h0C;
    localparam logic [5:0] IDX_STATUS   = 6'h10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int HOLD_LSB  = 4;
    localparam int FILT_LSB  = 0;
    localparam int SETUP_LSB = 4;
    localparam int DELAY_LSB = 2;
    localparam int FAST_BIT  = 1;
    localparam int WDDIS_BIT = 0;
    localparam int FREE_BIT  = 0;
    localparam int RECOV_BIT = 1;
    localparam logic [7:0] CTRL_ONE_RST = 8'h1C;
    localparam logic [7:0] CTRL_TWO_RST = 8'h10;
    localparam logic [7:0] HIGH_RST     = 8'h7A;
    localparam logic [7:0] LOW_RST      = 8'h7A;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // timing in its own units and derived cycle counts
    // ------------------------------------------------------------
    localparam int HOLD_UNIT_NS  = 50;
    localparam int FILT_UNIT_NS  = 5;
    localparam int SETUP_BASE_NS = 80;
    localparam int SETUP_UNIT_NS = 640;
    localparam int DELAY_BASE_NS = 240;
    localparam int DELAY_UNIT_NS = 40;
    localparam int SCL_UNIT_NS   = 40;
    localparam int SCL_EXTRA     = 4;
    localparam logic [3:0] RECOVER_PULSES = 4'h9;
    localparam int WDOG_FAST_US  = 50;
    localparam int WDOG_FAST_CYC = WDOG_FAST_US * 1000 / CLK_NS;
    localparam int WDOG_SLOW_S   = 1;
    localparam int WDOG_SLOW_CYC = WDOG_SLOW_S * 1000000000 / CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_S_DELAY = 3'h1,
        ST_S_SETUP = 3'h3,
        ST_R_LOW   = 3'h2,
        ST_R_HIGH  = 3'h6
    } link_state_t;

    // base + unit * n, in ns, at counter width
    function automatic logic [NSW-1:0] scaleNs(input logic [7:0] n, input int unit, input int base);
        scaleNs = NSW'(base + unit * int'(n));
    endfunction : scaleNs
endpackage : i2c_timing_pkg

// >>> i2c_timing_and_bus_watchdog.sv
// i2c timing and bus watchdog: axi4-lite registers on refClk, pin logic on linkClk
// assumes open-drain pins resolved outside; remote-access inputs come from refClk logic
// How it works
// - incoming SDA gets internal hold of hold setting times 50 ns, reset one
// - SCL and SDA pulses up to filter setting times 5 ns are rejected
// - remote ACK cycles: SDA setup before SCL rise is 80 ns plus 640 ns steps
// - SDA output follows SCL fall by 240 ns plus 40 ns per delay code
// - watchdog expires after about 50 us when fast select set, else one second
// - watchdog stops while its disable bit is set
// - SDA high and idle for the watchdog interval means the bus is free
// - SDA low and idle until expiry triggers nine recovery clocks on SCL
// - master SCL high phase lasts 40 ns times high count plus four
// - master SCL low phase lasts 40 ns times low count plus four
// - as slave outside ACK cycles, low count sets SDA setup before releasing stretched SCL
`timescale 1ns/1ps
`default_nettype none
module i2c_timing_and_bus_watchdog
    import i2c_timing_pkg::*;
#(
    parameter logic [WDW-1:0] WDOG_SLOW = WDW'(WDOG_SLOW_CYC)
) (
    input  wire logic          refClk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output var  logic          awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output var  logic          wready,
    output var  logic [1:0]    bresp,
    output var  logic          bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output var  logic          arready,
    output var  logic [31:0]   rdata,
    output var  logic [1:0]    rresp,
    output var  logic          rvalid,
    input  wire logic          rready,
    input  wire logic          remoteAccess,
    input  wire logic          remoteAckCycle,
    input  wire logic          remoteSdaBit,
    input  wire logic          linkClk,
    input  wire logic          sclIn,
    output var  logic          sclOut,
    output var  logic          sclOe,
    input  wire logic          sdaIn,
    output var  logic          sdaOut,
    output var  logic          sdaOe
);
    // ------------------------------------------------------------
    // register file and axi4-lite slave (refClk)
    // ------------------------------------------------------------
    logic [7:0]    ctrlOne;
    logic [7:0]    ctrlTwo;
    logic [7:0]    highCount;
    logic [7:0]    lowCount;
    logic          awHave;
    logic          wHave;
    logic [5:0]    awIdx;
    logic [7:0]    wByte;
    logic          wLane;
    logic [31:0]   cfgBus;
    logic          cfgReq;
    logic          ackS1;
    logic          ackS2;
    logic          freeS1;
    logic          freeS2;
    logic          recS1;
    logic          recS2;
    logic          cfgAck;
    logic          busFree;
    logic          recovering;

    function automatic logic idxMapped(input logic [5:0] idx);
        idxMapped = (idx == IDX_CTRL_ONE) || (idx == IDX_CTRL_TWO) || (idx == IDX_HIGH)
                 || (idx == IDX_LOW) || (idx == IDX_RSVD) || (idx == IDX_STATUS);
    endfunction : idxMapped

    wire         awTake    = awvalid & awready;
    wire         wTake     = wvalid & wready;
    wire         doWrite   = awHave & wHave & ~bvalid;
    wire         bDone     = bvalid & bready;
    wire         awHaveNx  = (awHave | awTake) & ~doWrite;
    wire         wHaveNx   = (wHave | wTake) & ~doWrite;
    wire         bvalidNx  = doWrite | (bvalid & ~bready);
    wire         wrHit     = doWrite & wLane;
    wire [5:0]   arIdx     = araddr[7:2];
    wire         arTake    = arvalid & arready;
    wire [7:0]   statusReg = {6'h00, recS2, freeS2};
    wire [7:0]   rdByte    = (arIdx == IDX_CTRL_ONE) ? ctrlOne :
                             (arIdx == IDX_CTRL_TWO) ? ctrlTwo :
                             (arIdx == IDX_HIGH)     ? highCount :
                             (arIdx == IDX_LOW)      ? lowCount :
                             (arIdx == IDX_STATUS)   ? statusReg : 8'h00;
    wire [31:0]  liveCfg   = {lowCount, highCount, ctrlTwo, ctrlOne};
    wire         cfgBusy   = cfgReq ^ ackS2;

    always_ff @(posedge refClk or posedge rst) begin
        if (rst) begin
            awHave  <= 1'b0;
            wHave   <= 1'b0;
            awIdx   <= 6'h00;
            wByte   <= 8'h00;
            wLane   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            awHave  <= awHaveNx;
            wHave   <= wHaveNx;
            awready <= ~awHaveNx & ~bvalidNx;
            wready  <= ~wHaveNx & ~bvalidNx;
            bvalid  <= bvalidNx;
            if (awTake) begin
                awIdx <= awaddr[7:2];
            end
            if (wTake) begin
                wByte <= wdata[7:0];
                wLane <= wstrb[0];
            end
            if (doWrite) begin
                bresp <= idxMapped(awIdx) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // status and reserved words ignore writes; only byte lane 0 carries data
    always_ff @(posedge refClk or posedge rst) begin
        if (rst) begin
            ctrlOne   <= CTRL_ONE_RST;
            ctrlTwo   <= CTRL_TWO_RST;
            highCount <= HIGH_RST;
            lowCount  <= LOW_RST;
        end else if (wrHit) begin
            if (awIdx == IDX_CTRL_ONE) begin
                ctrlOne <= wByte;
            end
            if (awIdx == IDX_CTRL_TWO) begin
                ctrlTwo <= wByte;
            end
            if (awIdx == IDX_HIGH) begin
                highCount <= wByte;
            end
            if (awIdx == IDX_LOW) begin
                lowCount <= wByte;
            end
        end
    end

    always_ff @(posedge refClk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arTake) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rdByte};
            rresp   <= idxMapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid & rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // crossings on the refClk side
    // ------------------------------------------------------------
    // config words go over a toggle handshake; cfgBus stays still while a request is open
    always_ff @(posedge refClk or posedge rst) begin
        if (rst) begin
            cfgBus <= {LOW_RST, HIGH_RST, CTRL_TWO_RST, CTRL_ONE_RST};
            cfgReq <= 1'b0;
            ackS1  <= 1'b0;
            ackS2  <= 1'b0;
            freeS1 <= 1'b0;
            freeS2 <= 1'b0;
            recS1  <= 1'b0;
            recS2  <= 1'b0;
        end else begin
            ackS1  <= cfgAck;
            ackS2  <= ackS1;
            freeS1 <= busFree;
            freeS2 <= freeS1;
            recS1  <= recovering;
            recS2  <= recS1;
            if (!cfgBusy && (cfgBus != liveCfg)) begin
                cfgBus <= liveCfg;
                cfgReq <= ~cfgReq;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: reset release, synchronisers, config capture
    // ------------------------------------------------------------
    logic          lrA;
    logic          linkRst;
    logic          reqS1;
    logic          reqS2;
    logic          reqS3;
    logic [31:0]   cfgL;
    logic [1:0]    pinS1;
    logic [1:0]    pinS2;
    logic [2:0]    remS1;
    logic [2:0]    remS2;

    // reset asserts at once, releases two linkClk edges later
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            lrA     <= 1'b1;
            linkRst <= 1'b1;
        end else begin
            lrA     <= 1'b0;
            linkRst <= lrA;
        end
    end

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            reqS1  <= 1'b0;
            reqS2  <= 1'b0;
            reqS3  <= 1'b0;
            cfgAck <= 1'b0;
            cfgL   <= {LOW_RST, HIGH_RST, CTRL_TWO_RST, CTRL_ONE_RST};
            pinS1  <= 2'h3;
            pinS2  <= 2'h3;
            remS1  <= 3'h0;
            remS2  <= 3'h0;
        end else begin
            reqS1 <= cfgReq;
            reqS2 <= reqS1;
            reqS3 <= reqS2;
            pinS1 <= {sdaIn, sclIn};
            pinS2 <= pinS1;
            remS1 <= {remoteSdaBit, remoteAckCycle, remoteAccess};
            remS2 <= remS1;
            if (reqS2 ^ reqS3) begin
                cfgL   <= cfgBus;
                cfgAck <= ~cfgAck;
            end
        end
    end

    wire [2:0]   holdSet  = cfgL[HOLD_LSB +: 3];
    wire [3:0]   filtSet  = cfgL[FILT_LSB +: 4];
    wire [7:0]   twoL     = cfgL[15:8];
    wire [3:0]   setupSet = twoL[SETUP_LSB +: 4];
    wire [1:0]   delaySet = twoL[DELAY_LSB +: 2];
    wire         fastSel  = twoL[FAST_BIT];
    wire         wdOff    = twoL[WDDIS_BIT];
    wire [7:0]   highL    = cfgL[23:16];
    wire [7:0]   lowL     = cfgL[31:24];
    wire         remAct   = remS2[0];
    wire         remAck   = remS2[1];
    wire         remSda   = remS2[2];

    // ------------------------------------------------------------
    // glitch filter and SDA hold
    // ------------------------------------------------------------
    localparam logic [NSW-1:0] STEP_NS = NSW'(CLK_NS);
    logic [1:0]    filt;
    logic [NSW-1:0] fCnt [2];
    logic          sdaHeld;
    logic [NSW-1:0] hCnt;
    logic          sclPrev;
    logic          sdaPrev;

    wire [NSW-1:0] filtNs = scaleNs({4'h0, filtSet}, FILT_UNIT_NS, 0);
    wire [NSW-1:0] holdNs = scaleNs({5'h00, holdSet}, HOLD_UNIT_NS, 0);

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            filt    <= 2'h3;
            fCnt[0] <= '0;
            fCnt[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pinS2[i] == filt[i]) begin
                    fCnt[i] <= '0;
                end else if (fCnt[i] + STEP_NS > filtNs) begin
                    filt[i] <= pinS2[i];
                    fCnt[i] <= '0;
                end else begin
                    fCnt[i] <= fCnt[i] + STEP_NS;
                end
            end
        end
    end

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            sdaHeld <= 1'b1;
            hCnt    <= '0;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= filt[0];
            sdaPrev <= sdaHeld;
            if (filt[1] == sdaHeld) begin
                hCnt <= '0;
            end else if (hCnt + STEP_NS >= holdNs) begin
                sdaHeld <= filt[1];
                hCnt    <= '0;
            end else begin
                hCnt <= hCnt + STEP_NS;
            end
        end
    end

    wire sclFall  = sclPrev & ~filt[0];
    wire activity = (sclPrev ^ filt[0]) | (sdaPrev ^ sdaHeld);

    // ------------------------------------------------------------
    // bus watchdog
    // ------------------------------------------------------------
    link_state_t   state;
    logic [WDW-1:0] wdCnt;
    logic          wdExp;

    wire [WDW-1:0] wdLimit = fastSel ? WDW'(WDOG_FAST_CYC) : WDOG_SLOW;

    // count idle cycles only while enabled, quiet and in ST_IDLE
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            wdCnt <= '0;
            wdExp <= 1'b0;
        end else if (wdOff || activity || state != ST_IDLE) begin
            wdCnt <= '0;
            wdExp <= 1'b0;
        end else begin
            wdExp <= (wdCnt == wdLimit - 1'b1);
            wdCnt <= (wdCnt == wdLimit - 1'b1) ? '0 : wdCnt + 1'b1;
        end
    end

    // free bus flag, dropped by any activity
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            busFree <= 1'b0;
        end else if (wdOff || activity) begin
            busFree <= 1'b0;
        end else if (wdExp && sdaHeld) begin
            busFree <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // SCL/SDA drive: slave stretch and recovery clocks
    // ------------------------------------------------------------
    logic [NSW-1:0] tCnt;
    logic [3:0]    pulses;

    wire [NSW-1:0] delayNs = scaleNs({6'h00, delaySet}, DELAY_UNIT_NS, DELAY_BASE_NS);
    wire [NSW-1:0] ackSuNs = scaleNs({4'h0, setupSet}, SETUP_UNIT_NS, SETUP_BASE_NS);
    // low count used for master low phase and slave data setup
    wire [NSW-1:0] lowNs   = scaleNs(lowL, SCL_UNIT_NS, SCL_UNIT_NS * SCL_EXTRA);
    wire [NSW-1:0] highNs  = scaleNs(highL, SCL_UNIT_NS, SCL_UNIT_NS * SCL_EXTRA);
    wire [NSW-1:0] target  = (state == ST_S_DELAY) ? delayNs :
                             (state == ST_S_SETUP) ? (remAck ? ackSuNs : lowNs) :
                             (state == ST_R_HIGH)  ? highNs : lowNs;
    wire           tDone   = (tCnt + STEP_NS >= target);

    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            state  <= ST_IDLE;
            tCnt   <= '0;
            pulses <= 4'h0;
            sclOe  <= 1'b0;
            sdaOe  <= 1'b0;
        end else begin
            tCnt <= (state == ST_IDLE || tDone) ? '0 : tCnt + STEP_NS;
            case (state)
                ST_IDLE: begin
                    if (!remAct) begin
                        sdaOe <= 1'b0;
                    end
                    if (remAct && sclFall) begin
                        sclOe <= 1'b1;
                        state <= ST_S_DELAY;
                    end else if (wdExp && !sdaHeld) begin
                        sclOe  <= 1'b1;
                        sdaOe  <= 1'b0;
                        pulses <= 4'h0;
                        state  <= ST_R_LOW;
                    end
                end
                ST_S_DELAY: begin
                    if (tDone) begin
                        sdaOe <= ~remSda;
                        state <= ST_S_SETUP;
                    end
                end
                ST_S_SETUP: begin
                    if (tDone) begin
                        sclOe <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_R_LOW: begin
                    if (tDone) begin
                        sclOe  <= 1'b0;
                        pulses <= pulses + 1'b1;
                        state  <= ST_R_HIGH;
                    end
                end
                ST_R_HIGH: begin
                    if (tDone && pulses == RECOVER_PULSES) begin
                        state <= ST_IDLE;
                    end else if (tDone) begin
                        sclOe <= 1'b1;
                        state <= ST_R_LOW;
                    end
                end
                default: begin
                    sclOe <= 1'b0;
                    sdaOe <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
            sclOut     <= 1'b0;
            sdaOut     <= 1'b0;
            recovering <= 1'b0;
        end else begin
            sclOut     <= 1'b0;
            sdaOut     <= 1'b0;
            recovering <= (state == ST_R_LOW) || (state == ST_R_HIGH);
        end
    end
endmodule : i2c_timing_and_bus_watchdog
`default_nettype wire

// >>> i2c_bus_partner.sv
// far side of the local bus: pull-up wires and a master that can hold sda or pull scl
// assumes the block only ever pulls its pins low
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
    input  wire logic sclOe,
    input  wire logic sdaOe,
    input  wire logic holdSdaLow,
    input  wire logic pullScl,
    output var  logic sclIn,
    output var  logic sdaIn
);
    // ----
    // wired-and with pull-up
    // ----
    // a released line reads the pull-up level, never a stale value
    assign sclIn = !(sclOe || pullScl);
    assign sdaIn = !(sdaOe || holdSdaLow);
endmodule : i2c_bus_partner
`default_nettype wire

// >>> i2c_timing_checker.sv
// assertions on the ports of the i2c timing block
// assumes remote accesses end with the block idle
`timescale 1ns/1ps
`default_nettype none
module i2c_timing_checker (
    input wire logic        refClk,
    input wire logic        linkClk,
    input wire logic        rst,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        remoteAccess,
    input wire logic        sclOut,
    input wire logic        sdaOut,
    input wire logic        sclOe,
    input wire logic        sdaOe
);
    // ----
    // register bus
    // ----
    sequence s_resp_done;
        bvalid && bready;
    endsequence
    sequence s_ready_back;
        !bvalid ##[0:1] (awready && wready);
    endsequence
    chk_write_answer: assert property (@(posedge refClk) disable iff (rst)
        awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid) else $error("write answer late");
    chk_bresp_hold: assert property (@(posedge refClk) disable iff (rst)
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
    chk_ready_return: assert property (@(posedge refClk) disable iff (rst)
        s_resp_done |=> s_ready_back) else $error("write readies not back");
    chk_read_answer: assert property (@(posedge refClk) disable iff (rst)
        arvalid && arready |=> rvalid && !arready) else $error("read answer late");
    chk_rdata_hold: assert property (@(posedge refClk) disable iff (rst)
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
    chk_upper_zero: assert property (@(posedge refClk) disable iff (rst)
        rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
    // ----
    // link pins
    // ----
    chk_pins_low: assert property (@(posedge linkClk) disable iff (rst)
        sclOut == 1'b0 && sdaOut == 1'b0) else $error("pin driven high");
    chk_scl_high_min: assert property (@(posedge linkClk) disable iff (rst)
        $fell(sclOe) |-> !sclOe [*8]) else $error("scl high too short");
    chk_scl_low_min: assert property (@(posedge linkClk) disable iff (rst)
        $rose(sclOe) |-> sclOe [*8]) else $error("scl low too short");
    chk_sda_quiet: assert property (@(posedge linkClk) disable iff (rst)
        !remoteAccess [*8] |-> !sdaOe) else $error("sda pulled while idle");
endmodule : i2c_timing_checker
bind i2c_timing_and_bus_watchdog i2c_timing_checker u_chk (.*);
`default_nettype wire

// >>> i2c_timing_and_bus_watchdog_tb.sv
// self-checking bench for the i2c timing block over axi4-lite
// assumes the partner model resolves the open-drain wires
`timescale 1ns/1ps
`default_nettype none
module i2c_timing_and_bus_watchdog_tb;
    import i2c_timing_pkg::*;
    logic refClk = 0, linkClk = 0, rst = 1;
    logic [AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic remoteAccess = 0, remoteAckCycle = 0, remoteSdaBit = 0;
    logic sclIn, sdaIn, sclOut, sclOe, sdaOut, sdaOe, holdSdaLow = 0, pullScl = 0;
    int fail_count = 0, checked = 0, rises = 0, hiRun = 0, gap = 0, hiLen = 0, gapLen = 0;
    always #10 refClk = ~refClk;
    initial begin
        #3.7;
        forever #15 linkClk = ~linkClk;
    end
    i2c_timing_and_bus_watchdog #(.WDOG_SLOW(WDW'(200))) u_dut (.*);
    i2c_bus_partner u_bus (.sclOe, .sdaOe, .holdSdaLow, .pullScl, .sclIn, .sdaIn);
    // ----
    // recovery pulse measurement
    // ----
    always @(posedge linkClk) begin
        if (sclOe) hiRun <= hiRun + 1;
        else gap <= gap + 1;
        if (sclOe && hiRun == 0) begin
            rises <= rises + 1;
            gapLen <= gap;
            gap <= 0;
        end
        if (!sclOe && hiRun != 0) begin
            hiLen <= hiRun;
            hiRun <= 0;
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic hang();
        fail_count++;
        summarize();
    endtask : hang
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // ----
    // bus cycles
    // ----
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge refClk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (n < 50) begin
            @(posedge refClk);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                r = bresp;
                bready <= 0;
                n = 99;
            end
        end
        if (n == 50) hang();
    endtask : wr
    task automatic rd(input logic [5:0] idx);
        int n;
        n = 0;
        @(posedge refClk);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        while (n < 50) begin
            @(posedge refClk);
            n++;
            if (arready) arvalid <= 0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 0;
                n = 99;
            end
        end
        if (n == 50) hang();
    endtask : rd
    task automatic poll(input int b, input logic v);
        int n;
        for (n = 0; n < 300; n++) begin
            rd(IDX_STATUS);
            if (d[b] === v) break;
        end
        check("status bit", 32'(d[b]), 32'(v));
        if (n == 300) summarize();
    endtask : poll
    task automatic pulse(input int len);
        @(posedge linkClk) pullScl <= 1;
        repeat (len) @(posedge linkClk);
        pullScl <= 0;
        repeat (20) @(posedge refClk);
    endtask : pulse
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        rd(IDX_CTRL_ONE);
        check("ctrl one", d, 32'h1C);
        rd(IDX_CTRL_TWO);
        check("ctrl two", d, 32'h10);
        rd(IDX_HIGH);
        check("high count", d, 32'h7A);
        rd(IDX_LOW);
        check("low count", d, 32'h7A);
        wr(IDX_RSVD, 8'h55);
        rd(IDX_RSVD);
        check("reserved", d, 32'h0);
        wr(6'h3F, 8'h11);
        check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
        wr(IDX_HIGH, 8'h03);
        rd(IDX_HIGH);
        check("high write", d, 32'h03);
        $display("regs test done");
    endtask : t_regs
    task automatic t_free();
        wr(IDX_CTRL_TWO, 8'h00);
        poll(FREE_BIT, 1'b1);
        pulse(1);
        rd(IDX_STATUS);
        check("glitch ignored", 32'(d[FREE_BIT]), 32'h1);
        pulse(10);
        rd(IDX_STATUS);
        check("free cleared", 32'(d[FREE_BIT]), 32'h0);
        poll(FREE_BIT, 1'b1);
        $display("free test done");
    endtask : t_free
    task automatic t_disable();
        wr(IDX_CTRL_TWO, 8'h01);
        pulse(10);
        repeat (900) @(posedge refClk);
        rd(IDX_STATUS);
        check("watchdog off", 32'(d[FREE_BIT]), 32'h0);
        $display("disable test done");
    endtask : t_disable
    task automatic t_recover();
        int n;
        wr(IDX_LOW, 8'h02);
        wr(IDX_CTRL_TWO, 8'h02);
        repeat (20) @(posedge refClk);
        rises = 0;
        @(posedge linkClk) holdSdaLow <= 1;
        for (n = 0; n < 3000 && !sclOe; n++) @(posedge linkClk);
        check("fast expiry", 32'(n >= 2400 && n < 3000), 32'h1);
        holdSdaLow <= 0;
        repeat (600) @(posedge linkClk);
        check("recovery pulses", rises, 32'd9);
        check("scl low len", hiLen, 32'd12);
        check("scl high len", gapLen, 32'd14);
        $display("recover test done");
    endtask : t_recover
    task automatic t_remote();
        {remoteAccess, remoteAckCycle} <= 2'b11;
        pulse(10);
        check("slave sda", 32'(sdaIn), 32'h0);
        repeat (20) @(posedge refClk);
        check("slave stretch", hiLen, 32'd16);
        remoteAccess <= 0;
        $display("remote test done");
    endtask : t_remote
    initial begin
        repeat (20) @(posedge refClk);
        rst <= 0;
        repeat (5) @(posedge refClk);
        t_regs();
        t_free();
        t_disable();
        t_recover();
        t_remote();
        summarize();
    end
endmodule : i2c_timing_and_bus_watchdog_tb
`default_nettype wire
